// *** rtl/reset_source_pkg.sv ***
// Shared constants of the reset-source and watchdog block.
// Assumes a single 125 MHz system clock and an 8-bit register port.
`default_nettype none
package reset_source_pkg;
	// Register offsets on the plain register port
	localparam logic [7:0] RESET_CAUSE_ADDR = 8'hef;
	localparam logic [7:0] WATCHDOG_CTRL_ADDR = 8'hff;

	// Reset cause register bit positions
	localparam int PIN_BIT = 0;
	localparam int POWER_ON_BIT = 1;
	localparam int MISSING_CLOCK_BIT = 2;
	localparam int WATCHDOG_BIT = 3;
	localparam int SOFTWARE_BIT = 4;
	localparam int COMPARATOR_BIT = 5;
	localparam int CONVERT_START_BIT = 6;
	localparam int DEBUG_PORT_BIT = 7;
	localparam int NUM_CAUSES = 7;

	// Watchdog control register fields and command bytes
	localparam int WDT_ACTIVE_BIT = 4;
	localparam int WDT_CMD_BIT = 7;
	localparam logic [7:0] WDT_CMD_RESTART = 8'ha5;
	localparam logic [7:0] WDT_CMD_DISABLE_FIRST = 8'hde;
	localparam logic [7:0] WDT_CMD_DISABLE_SECOND = 8'had;
	localparam logic [7:0] WDT_CMD_LOCK = 8'hff;
	localparam logic [2:0] WDT_INTERVAL_RESET = 3'h7;
	localparam int WDT_WIDTH = 21;
	localparam int WDT_BASE_EXP = 3;
	localparam logic [2:0] WDT_DISABLE_WINDOW = 3'h4;

	// Timing
	localparam int CLK_HZ = 125_000_000;
	localparam int STRETCH_CYCLES = 12;
	localparam int POWER_ON_HOLD_MS = 100;
	localparam int POWER_ON_HOLD_CYCLES = POWER_ON_HOLD_MS * (CLK_HZ / 1000);

	// Idle levels of the pin inputs, in synchroniser order
	// {debug_in_reset, missing_clock, comparator_below, convert_start_n, rst_pin_n}
	localparam logic [4:0] PIN_IDLE = 5'h03;
endpackage
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-flop synchronisers for asynchronous pin inputs.
// Assumes inputs come from outside the sys_clk domain.
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_t;

	sync_t cur_ff;
	sync_t nxt_ff;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("pin_sync needs WIDTH of at least one");
		end
	endgenerate

	always_comb begin
		nxt_ff.first = async_in;
		nxt_ff.second = cur_ff.first;
		if (!rstn) begin
			nxt_ff.first = IDLE;
			nxt_ff.second = IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		cur_ff <= nxt_ff;
	end

	assign sync_out = cur_ff.second;
endmodule
`default_nettype wire

// *** rtl/reset_source_and_watchdog.sv ***
// Reset-source sequencer, reset cause register and 21-bit watchdog timer.
// Assumes rstn is the supply monitor's power-on reset, synchronous to sys_clk,
// and that the rest of the chip is held while core_reset_n is low.
`default_nettype none
module reset_source_and_watchdog #(
	parameter int POWER_ON_HOLD = reset_source_pkg::POWER_ON_HOLD_CYCLES,
	parameter int WDT_W = reset_source_pkg::WDT_WIDTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic rst_pin_n_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	input wire logic convert_start_input_n,
	input wire logic comparator_below,
	input wire logic missing_clock_reset,
	input wire logic debug_port_in_reset,
	output logic core_reset_n
);
	localparam int HOLD_W = $clog2(POWER_ON_HOLD + 1);
	localparam logic [3:0] STRETCH_LOAD = 4'(reset_source_pkg::STRETCH_CYCLES);

	typedef enum logic [1:0] {
		SEQ_RUN,
		SEQ_HOLD,
		SEQ_STRETCH
	} seq_t;

	typedef struct packed {
		seq_t seq;
		logic [3:0] stretch;
		logic [HOLD_W-1:0] hold_cnt;
		logic pin_drive;
		logic [reset_source_pkg::NUM_CAUSES-1:0] cause;
		logic cmp_en;
		logic cnv_en;
		logic wdt_on;
		logic wdt_lock;
		logic [2:0] wdt_iv;
		logic [WDT_W-1:0] wdt_cnt;
		logic [2:0] dis_win;
		logic [7:0] rdata;
	} state_t;

	state_t cur_ff;
	state_t nxt_ff;

	logic [4:0] pins_sync;
	logic pin_low;
	logic cnv_low;
	logic cmp_low;
	logic mcd;
	logic dbg_rst;
	logic [reset_source_pkg::NUM_CAUSES-1:0] events;
	logic level_active;
	logic wdt_overflow;
	logic cause_wr;
	logic ctrl_wr;
	logic [1:0] addr_sel;

	generate
		if (WDT_W < reset_source_pkg::WDT_WIDTH) begin : g_wdt_chk
			$error("watchdog counter must be at least 21 bits");
		end
		if (POWER_ON_HOLD < 1) begin : g_hold_chk
			$error("power-on hold must be at least one cycle");
		end
		if (reset_source_pkg::STRETCH_CYCLES < 1 ||
			reset_source_pkg::STRETCH_CYCLES > 15) begin : g_stretch_chk
			$error("reset stretch must fit the four-bit counter");
		end
	endgenerate

	pin_sync #(
		.WIDTH(5),
		.IDLE(reset_source_pkg::PIN_IDLE)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_in({debug_port_in_reset, missing_clock_reset, comparator_below,
			convert_start_input_n, rst_pin_n_in}),
		.sync_out(pins_sync)
	);

	assign pin_low = ~pins_sync[0];
	assign cnv_low = ~pins_sync[1];
	assign cmp_low = pins_sync[2];
	assign mcd = pins_sync[3];
	assign dbg_rst = pins_sync[4];

	// Timeout less one: 4**(3+iv) = 2**(6+2*iv)
	function automatic logic [WDT_W-1:0] wdt_last(input logic [2:0] iv);
		logic [4:0] shamt;
		shamt = 5'(2 * reset_source_pkg::WDT_BASE_EXP) + {1'b0, iv, 1'b0};
		wdt_last = (WDT_W'(1) << shamt) - WDT_W'(1);
	endfunction

	// Fixed priority when several sources hit in one cycle
	function automatic logic [reset_source_pkg::NUM_CAUSES-1:0] pick_cause(
		input logic [reset_source_pkg::NUM_CAUSES-1:0] ev
	);
		logic [reset_source_pkg::NUM_CAUSES-1:0] one;
		one = '0;
		if (ev[reset_source_pkg::POWER_ON_BIT]) begin
			one[reset_source_pkg::POWER_ON_BIT] = 1'b1;
		end else if (ev[reset_source_pkg::PIN_BIT]) begin
			one[reset_source_pkg::PIN_BIT] = 1'b1;
		end else if (ev[reset_source_pkg::MISSING_CLOCK_BIT]) begin
			one[reset_source_pkg::MISSING_CLOCK_BIT] = 1'b1;
		end else if (ev[reset_source_pkg::WATCHDOG_BIT]) begin
			one[reset_source_pkg::WATCHDOG_BIT] = 1'b1;
		end else if (ev[reset_source_pkg::COMPARATOR_BIT]) begin
			one[reset_source_pkg::COMPARATOR_BIT] = 1'b1;
		end else if (ev[reset_source_pkg::CONVERT_START_BIT]) begin
			one[reset_source_pkg::CONVERT_START_BIT] = 1'b1;
		end else if (ev[reset_source_pkg::SOFTWARE_BIT]) begin
			one[reset_source_pkg::SOFTWARE_BIT] = 1'b1;
		end
		pick_cause = one;
	endfunction

	// Register select: bit 0 the reset cause register, bit 1 watchdog control
	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		logic [1:0] sel;
		sel = 2'h0;
		if (a == reset_source_pkg::RESET_CAUSE_ADDR) begin
			sel[0] = 1'b1;
		end
		if (a == reset_source_pkg::WATCHDOG_CTRL_ADDR) begin
			sel[1] = 1'b1;
		end
		reg_sel = sel;
	endfunction

	// Writes land only while the sequencer runs; reads are answered in any state
	assign addr_sel = reg_sel(addr);
	assign cause_wr = wr && addr_sel[0] &&
		(cur_ff.seq == SEQ_RUN);
	assign ctrl_wr = wr && addr_sel[1] &&
		(cur_ff.seq == SEQ_RUN);
	// Greater-or-equal, so a shorter interval written over a higher count still bites
	assign wdt_overflow = cur_ff.wdt_on && (cur_ff.wdt_cnt >= wdt_last(cur_ff.wdt_iv));

	always_comb begin
		events = '0;
		// The block's own drive pulls the pin low; that is not an external reset
		events[reset_source_pkg::PIN_BIT] = pin_low && !cur_ff.pin_drive;
		events[reset_source_pkg::POWER_ON_BIT] =
			cause_wr && wdata[reset_source_pkg::POWER_ON_BIT];
		events[reset_source_pkg::MISSING_CLOCK_BIT] = mcd;
		events[reset_source_pkg::WATCHDOG_BIT] = wdt_overflow;
		events[reset_source_pkg::SOFTWARE_BIT] =
			cause_wr && wdata[reset_source_pkg::SOFTWARE_BIT];
		events[reset_source_pkg::COMPARATOR_BIT] = cur_ff.cmp_en && cmp_low;
		events[reset_source_pkg::CONVERT_START_BIT] = cur_ff.cnv_en && cnv_low;
	end

	// Level sources keep the chip in reset for as long as they stay asserted
	assign level_active = events[reset_source_pkg::PIN_BIT] ||
		events[reset_source_pkg::MISSING_CLOCK_BIT] ||
		events[reset_source_pkg::COMPARATOR_BIT] ||
		events[reset_source_pkg::CONVERT_START_BIT] ||
		cur_ff.pin_drive;

	always_comb begin
		nxt_ff = cur_ff;

		// Register read data stand in the cycle after the strobe
		nxt_ff.rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				reset_source_pkg::RESET_CAUSE_ADDR: begin
					nxt_ff.rdata = {dbg_rst, cur_ff.cause};
				end
				reset_source_pkg::WATCHDOG_CTRL_ADDR: begin
					nxt_ff.rdata[2:0] = cur_ff.wdt_iv;
					nxt_ff.rdata[reset_source_pkg::WDT_ACTIVE_BIT] = cur_ff.wdt_on;
				end
				default: begin
					nxt_ff.rdata = 8'h00;
				end
			endcase
		end

		// Forced power-on keeps the pin low for the whole hold count
		if (cur_ff.pin_drive) begin
			if (cur_ff.hold_cnt <= HOLD_W'(1)) begin
				nxt_ff.pin_drive = 1'b0;
				nxt_ff.hold_cnt = '0;
			end else begin
				nxt_ff.hold_cnt = cur_ff.hold_cnt - HOLD_W'(1);
			end
		end

		unique case (cur_ff.seq)
			SEQ_RUN: begin
				// Disable window closes four clocks after the first byte
				if (cur_ff.dis_win != 3'h0) begin
					nxt_ff.dis_win = cur_ff.dis_win - 3'h1;
				end
				if (cur_ff.wdt_on) begin
					nxt_ff.wdt_cnt = cur_ff.wdt_cnt + WDT_W'(1);
				end
				// Every cause write replaces both source enables
				if (cause_wr) begin
					nxt_ff.cmp_en = wdata[reset_source_pkg::COMPARATOR_BIT];
					nxt_ff.cnv_en = wdata[reset_source_pkg::CONVERT_START_BIT];
				end
				// Command bytes first; other bytes with bit 7 low set the interval
				if (ctrl_wr) begin
					unique case (wdata)
						reset_source_pkg::WDT_CMD_RESTART: begin
							nxt_ff.wdt_on = 1'b1;
							nxt_ff.wdt_cnt = '0;
						end
						reset_source_pkg::WDT_CMD_DISABLE_FIRST: begin
							nxt_ff.dis_win = reset_source_pkg::WDT_DISABLE_WINDOW;
						end
						reset_source_pkg::WDT_CMD_DISABLE_SECOND: begin
							if (cur_ff.dis_win != 3'h0 && !cur_ff.wdt_lock) begin
								nxt_ff.wdt_on = 1'b0;
								nxt_ff.wdt_cnt = '0;
							end
							nxt_ff.dis_win = 3'h0;
						end
						reset_source_pkg::WDT_CMD_LOCK: begin
							nxt_ff.wdt_lock = 1'b1;
						end
						default: begin
							if (!wdata[reset_source_pkg::WDT_CMD_BIT]) begin
								nxt_ff.wdt_iv = wdata[2:0];
							end
						end
					endcase
				end
				if (events != '0) begin
					// Whole cause field is replaced, so bit 1 clears on other causes
					nxt_ff.cause = pick_cause(events);
					nxt_ff.seq = SEQ_HOLD;
					nxt_ff.wdt_on = 1'b0;
					if (events[reset_source_pkg::POWER_ON_BIT]) begin
						nxt_ff.pin_drive = 1'b1;
						nxt_ff.hold_cnt = HOLD_W'(POWER_ON_HOLD);
					end
				end
			end
			SEQ_HOLD: begin
				// Wait until every level source and the pin drive have let go
				if (!level_active) begin
					nxt_ff.seq = SEQ_STRETCH;
					nxt_ff.stretch = STRETCH_LOAD;
				end
			end
			SEQ_STRETCH: begin
				if (level_active) begin
					nxt_ff.seq = SEQ_HOLD;
				end else if (cur_ff.stretch <= 4'h1) begin
					// Leave reset with enables and lock clear, watchdog at longest interval
					nxt_ff.seq = SEQ_RUN;
					nxt_ff.stretch = 4'h0;
					nxt_ff.cmp_en = 1'b0;
					nxt_ff.cnv_en = 1'b0;
					nxt_ff.wdt_on = 1'b1;
					nxt_ff.wdt_lock = 1'b0;
					nxt_ff.wdt_iv = reset_source_pkg::WDT_INTERVAL_RESET;
					nxt_ff.wdt_cnt = '0;
					nxt_ff.dis_win = 3'h0;
				end else begin
					nxt_ff.stretch = cur_ff.stretch - 4'h1;
				end
			end
			default: begin
				// Unused state code: fall back into the reset stretch
				nxt_ff.seq = SEQ_STRETCH;
				nxt_ff.stretch = STRETCH_LOAD;
			end
		endcase

		// Supply-monitor reset: power-on flag only, then the full stretch
		if (!rstn) begin
			nxt_ff.seq = SEQ_STRETCH;
			nxt_ff.stretch = STRETCH_LOAD;
			nxt_ff.hold_cnt = '0;
			nxt_ff.pin_drive = 1'b0;
			nxt_ff.cause = '0;
			nxt_ff.cause[reset_source_pkg::POWER_ON_BIT] = 1'b1;
			nxt_ff.cmp_en = 1'b0;
			nxt_ff.cnv_en = 1'b0;
			nxt_ff.wdt_on = 1'b0;
			nxt_ff.wdt_lock = 1'b0;
			nxt_ff.wdt_iv = reset_source_pkg::WDT_INTERVAL_RESET;
			nxt_ff.wdt_cnt = '0;
			nxt_ff.dis_win = 3'h0;
			nxt_ff.rdata = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		cur_ff <= nxt_ff;
	end

	assign rdata = cur_ff.rdata;
	// Open-drain pin: only ever pulled low, and only for a forced power-on reset
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe = cur_ff.pin_drive;
	// Raw comparator level joins the core reset so it acts with the clock stopped
	assign core_reset_n = (cur_ff.seq == SEQ_RUN) && rstn &&
		!(cur_ff.cmp_en && comparator_below);
endmodule
`default_nettype wire

// *** bench/rsw_chk.sv ***
// Checker: read timing, reset stretch and reset-pin drive at the block's ports.
// Assumes it is bound to reset_source_and_watchdog and sees its ports only.
`default_nettype none
module rsw_chk #(
	parameter int POWER_ON_HOLD = 20,
	parameter int WDT_W = 21
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic rst_pin_n_in,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe,
	input wire logic debug_port_in_reset,
	input wire logic core_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int oe_cnt_ff;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	// Length of the current pin drive
	always_ff @(posedge sys_clk) begin
		oe_cnt_ff <= (rstn && rst_pin_oe) ? oe_cnt_ff + 1 : 0;
	end
	a_read_idle_zero: assert property (!rd |=> rdata == 8'h00)
		else $error("rdata not zero without read");
	a_ctrl_read_fmt: assert property (
		rd && addr == 8'hff |=> rdata[7:5] == 3'h0 && !rdata[3])
		else $error("watchdog control read format wrong");
	a_debug_bit_live: assert property (
		(debug_port_in_reset [*4] ##0 (rd && addr == 8'hef)) |=> rdata[7])
		else $error("debug reset bit not shown");
	a_release_stretch: assert property (
		$rose(rstn) |-> !core_reset_n [*8] ##1 !core_reset_n [*4] ##1 core_reset_n)
		else $error("reset release stretch wrong");
	a_pin_stretch: assert property (
		$rose(rst_pin_n_in) |-> !core_reset_n [*8] ##1 !core_reset_n [*4])
		else $error("reset left too soon after pin release");
	a_por_drives_pin: assert property (
		wr && addr == 8'hef && wdata[1] && core_reset_n
		|-> ##[1:3] (rst_pin_oe && !rst_pin_out && !rst_pin_n_in))
		else $error("forced power-on reset does not pull pin");
	a_sw_pin_quiet: assert property (
		wr && addr == 8'hef && !wdata[1] && !rst_pin_oe |=> !rst_pin_oe [*4])
		else $error("pin driven by non power-on write");
	a_oe_hold_len: assert property (
		$fell(rst_pin_oe) |-> oe_cnt_ff + 2 >= POWER_ON_HOLD && oe_cnt_ff <= POWER_ON_HOLD + 2)
		else $error("pin drive length wrong");
	a_pin_only_por: assert property (
		$rose(rst_pin_oe) |-> $past(wr) && $past(addr) == 8'hef && $past(wdata[1]))
		else $error("reset pin driven without power-on request");
	a_wdt_defaults: assert property (
		$rose(core_reset_n) ##1 (rd && addr == 8'hff) |=> rdata == 8'h17)
		else $error("watchdog not running at longest interval");
	c_wdt_bite: cover property (core_reset_n ##1 (!core_reset_n && !rst_pin_oe));
	c_por_force: cover property ($rose(rst_pin_oe));
	c_ctrl_read: cover property (rd && addr == 8'hff);
endmodule
bind reset_source_and_watchdog rsw_chk #(.POWER_ON_HOLD(POWER_ON_HOLD), .WDT_W(WDT_W)) chk (
	.sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .rst_pin_n_in, .rst_pin_out,
	.rst_pin_oe, .debug_port_in_reset, .core_reset_n);
`default_nettype wire

// *** bench/far_side.sv ***
// Surroundings model: open-drain reset pin, comparator and convert-start pin.
// Assumes the bench commands it; the pin has a weak pull-up.
`default_nettype none
module far_side #(
	parameter int SETTLE = 2500
) (
	input wire logic sys_clk,
	input wire logic pull_low,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe,
	output logic rst_pin_n_in,
	input wire logic cmp_on,
	input wire logic [7:0] cmp_plus,
	input wire logic [7:0] cmp_minus,
	output logic comparator_below,
	input wire logic cnv_routed,
	input wire logic cnv_level,
	output logic convert_start_input_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int on_cnt = 0;
	logic chatter = 1'b0;
	assign rst_pin_n_in = !((rst_pin_oe && !rst_pin_out) || pull_low);
	always @(posedge sys_clk) begin
		on_cnt <= cmp_on ? on_cnt + 1 : 0;
		chatter <= !chatter;
	end
	// Output chatters until the comparator has settled after turn-on
	assign comparator_below = (on_cnt < SETTLE) ? (cmp_on && chatter) : (cmp_plus < cmp_minus);
	// Unrouted convert-start reads as the port's idle high level
	assign convert_start_input_n = cnv_routed ? cnv_level : 1'b1;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench: register reads, watchdog commands and every reset cause.
// Assumes the checker is bound to the design and far_side drives the pins.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pull_low = 1'b0;
	logic cmp_on = 1'b0;
	logic [7:0] cmp_plus = 8'h80;
	logic [7:0] cmp_minus = 8'h40;
	logic cnv_routed = 1'b0;
	logic cnv_level = 1'b1;
	logic missing_clock_reset = 1'b0;
	logic debug_port_in_reset = 1'b0;
	logic [7:0] rdata;
	logic rst_pin_n_in, rst_pin_out, rst_pin_oe;
	logic comparator_below, convert_start_input_n, core_reset_n;
	int error_cnt = 0;
	int compares = 0;
	int n;
	// Columns: write address, write data, read address, expected read
	logic [31:0] rows [6] = '{32'h0000_ef02, 32'h0000_ff17, 32'hff03_ff13,
		32'hff85_ff13, 32'h1055_1000, 32'hffff_ff13};
	always #4 sys_clk = ~sys_clk;
	reset_source_and_watchdog #(.POWER_ON_HOLD(20)) dut (.sys_clk, .rstn, .addr, .wdata, .wr,
		.rd, .rdata, .rst_pin_n_in, .rst_pin_out, .rst_pin_oe, .convert_start_input_n,
		.comparator_below, .missing_clock_reset, .debug_port_in_reset, .core_reset_n);
	far_side fs (.sys_clk, .pull_low, .rst_pin_out, .rst_pin_oe, .rst_pin_n_in, .cmp_on,
		.cmp_plus, .cmp_minus, .comparator_below, .cnv_routed, .cnv_level,
		.convert_start_input_n);
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		check(rdata, exp);
	endtask
	task automatic wait_core(input logic lvl, output int cyc);
		cyc = 0;
		do begin
			@(negedge sys_clk);
			cyc++;
		end while (core_reset_n !== lvl && cyc < 5000);
		if (core_reset_n !== lvl) begin
			error_cnt++;
			$display("Error at %0t: core reset wait timed out", $time);
			report_and_stop();
		end
	endtask
	task automatic after_reset(input logic [7:0] cause, output int cyc);
		wait_core(1'b1, cyc);
		rd_chk(8'hff, 8'h17);
		rd_chk(8'hef, cause);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		wait_core(1'b1, n);
		for (int i = 0; i < 6; i++) begin
			wr_reg(rows[i][31:24], rows[i][23:16]);
			rd_chk(rows[i][15:8], rows[i][7:0]);
		end
		wr_reg(8'hef, 8'h10);
		wait_core(1'b0, n);
		after_reset(8'h10, n);
		wr_reg(8'hff, 8'hde);
		wr_reg(8'hff, 8'had);
		rd_chk(8'hff, 8'h07);
		wr_reg(8'hff, 8'ha5);
		rd_chk(8'hff, 8'h17);
		wr_reg(8'hff, 8'hde);
		repeat (4) @(posedge sys_clk);
		wr_reg(8'hff, 8'had);
		rd_chk(8'hff, 8'h17);
		wr_reg(8'hff, 8'hff);
		wr_reg(8'hff, 8'hde);
		wr_reg(8'hff, 8'had);
		rd_chk(8'hff, 8'h17);
		for (int iv = 0; iv < 2; iv++) begin
			wr_reg(8'hff, {5'h00, iv[2:0]});
			wr_reg(8'hff, 8'ha5);
			repeat (40) @(posedge sys_clk);
			wr_reg(8'hff, 8'ha5);
			wait_core(1'b0, n);
			check({7'h00, n >= (1 << (6 + 2 * iv)) - 1 && n <= (1 << (6 + 2 * iv)) + 1}, 8'h01);
			after_reset(8'h08, n);
		end
		repeat (80) @(posedge sys_clk);
		wr_reg(8'hff, 8'h00);
		wait_core(1'b0, n);
		check({7'h00, n == 2}, 8'h01);
		after_reset(8'h08, n);
		@(posedge sys_clk);
		pull_low <= 1'b1;
		repeat (10) @(posedge sys_clk);
		pull_low <= 1'b0;
		after_reset(8'h01, n);
		check({7'h00, n >= 12}, 8'h01);
		@(posedge sys_clk);
		missing_clock_reset <= 1'b1;
		debug_port_in_reset <= 1'b1;
		wait_core(1'b0, n);
		@(posedge sys_clk);
		missing_clock_reset <= 1'b0;
		after_reset(8'h84, n);
		@(posedge sys_clk);
		debug_port_in_reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd_chk(8'hef, 8'h04);
		@(posedge sys_clk);
		cnv_routed <= 1'b1;
		wr_reg(8'hef, 8'h40);
		@(posedge sys_clk);
		cnv_level <= 1'b0;
		wait_core(1'b0, n);
		@(posedge sys_clk);
		cnv_level <= 1'b1;
		after_reset(8'h40, n);
		@(posedge sys_clk);
		cmp_on <= 1'b1;
		repeat (2600) @(posedge sys_clk);
		wr_reg(8'hef, 8'h20);
		wr_reg(8'hef, 8'h00);
		@(posedge sys_clk);
		cmp_plus <= 8'h20;
		repeat (8) @(negedge sys_clk);
		check({7'h00, core_reset_n}, 8'h01);
		wr_reg(8'hef, 8'h20);
		@(negedge sys_clk);
		check({7'h00, core_reset_n}, 8'h00);
		@(posedge sys_clk);
		cmp_plus <= 8'h80;
		after_reset(8'h20, n);
		wr_reg(8'hef, 8'h02);
		wait_core(1'b0, n);
		repeat (2) @(negedge sys_clk);
		check({7'h00, rst_pin_n_in}, 8'h00);
		after_reset(8'h02, n);
		report_and_stop();
	end
endmodule
`default_nettype wire
